/* include/crs_pkg.sv */
// Package with constants and carrier types for the CPU core register set
package crs_pkg;
    // Flag bit positions in the flags register
    localparam int FLAG_CARRY_POS = 0;
    localparam int FLAG_ZERO_POS = 1;
    localparam int FLAG_NEG_POS = 2;
    localparam int FLAG_MASK_POS = 3;
    localparam int FLAG_HALF_POS = 4;
    // Bits 7..5 always read one
    localparam logic [7:0] FLAGS_FIXED_ONES = 8'he0;
    // Reset value: fixed ones plus mask set, undefined bits taken as zero
    localparam logic [7:0] FLAGS_RESET = 8'he8;
    // Stack pointer reset value, top of stack
    localparam logic [15:0] SP_RESET = 16'h017f;
    // Fixed upper part of the stack pointer (upper ten bits)
    localparam logic [9:0] SP_FIXED_HIGH = 10'h005;
    // Low six bits at reset, all ones
    localparam logic [5:0] SP_LOW_RESET = 6'h3f;
    // Bytes used by a call and by an interrupt entry
    localparam int CALL_STACK_BYTES = 2;
    localparam int IRQ_STACK_BYTES = 5;
    // Reset values of the data registers
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam logic [15:0] PC_RESET = 16'h0000;

    // Operations that change the register set
    typedef enum logic [3:0] {
        CRS_OP_NONE,
        CRS_OP_WRITE_ACC,
        CRS_OP_WRITE_IDX_X,
        CRS_OP_WRITE_IDX_Y,
        CRS_OP_LOAD_PC,
        CRS_OP_PUSH,
        CRS_OP_POP,
        CRS_OP_LOAD_SP_LOW,
        CRS_OP_RESET_SP,
        CRS_OP_IRQ_ENTRY,
        CRS_OP_IRQ_RETURN,
        CRS_OP_CALL
    } crs_op_e;

    // Selector of the register pushed or popped by a plain stack op
    typedef enum logic [1:0] {
        CRS_SEL_ACC,
        CRS_SEL_IDX_X,
        CRS_SEL_IDX_Y,
        CRS_SEL_FLAGS
    } crs_sel_e;

    // Flag update from the ALU; negative and zero share one enable, mask has set and clear
    typedef struct packed {
        logic half_en;
        logic half_val;
        logic nz_en;
        logic carry_en;
        logic carry_val;
        logic mask_set;
        logic mask_clear;
    } crs_flag_upd_s;

    // Stack memory port
    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] addr;
        logic [7:0] data;
    } crs_stack_req_s;
endpackage : crs_pkg

/* rtl/crs_stack_ptr.sv */
// Stack pointer with fixed upper bits and a wrapping six-bit low part
`timescale 1ns/10ps
module crs_stack_ptr #(
    parameter int LOW_W = 6
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic dec,
    input wire logic inc,
    input wire logic load_low,
    input wire logic reset_top,
    input wire logic [7:0] low_in,
    output logic [15:0] sp
);
    logic [LOW_W-1:0] low_reg; // Varying low bits
    logic [LOW_W-1:0] low_next;

    // Next value: reset op wins, then load, then count; wrap is silent
    always_comb begin
        low_next = low_reg;
        if (reset_top) begin
            low_next = crs_pkg::SP_LOW_RESET;
        end else if (load_low) begin
            low_next = low_in[LOW_W-1:0];
        end else if (dec && !inc) begin
            low_next = low_reg - 1'b1;
        end else if (inc && !dec) begin
            low_next = low_reg + 1'b1;
        end
    end

    // Register only
    always_ff @(posedge clk) begin
        if (rst) begin
            low_reg <= crs_pkg::SP_LOW_RESET;
        end else if (ce) begin
            low_reg <= low_next;
        end
    end

    // Upper ten bits forced by hardware
    assign sp = {crs_pkg::SP_FIXED_HIGH, low_reg};

    chk_sp_high_fixed: assert property (@(posedge clk) disable iff (rst)
        sp[15:6] == crs_pkg::SP_FIXED_HIGH) else $error("stack pointer high bits moved");
    chk_sp_reset_top: assert property (@(posedge clk) disable iff (rst)
        ce && reset_top |=> low_reg == 6'h3f) else $error("reset-stack op missed top");
endmodule : crs_stack_ptr

/* rtl/crs_flags.sv */
// Flags register with fixed ones in the top three bits
`timescale 1ns/10ps
module crs_flags (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire crs_pkg::crs_flag_upd_s upd,
    input wire logic [7:0] result,
    input wire logic load,
    input wire logic [7:0] load_val,
    output logic [7:0] flags
);
    logic [4:0] low_reg; // H I N Z C
    logic [4:0] low_next;

    // Next flags: whole load (pop or return) first, then per-flag updates
    always_comb begin
        low_next = low_reg;
        if (load) begin
            low_next = load_val[4:0];
        end else begin
            if (upd.half_en) begin
                low_next[crs_pkg::FLAG_HALF_POS] = upd.half_val;
            end
            if (upd.nz_en) begin
                low_next[crs_pkg::FLAG_NEG_POS] = result[7];
                low_next[crs_pkg::FLAG_ZERO_POS] = (result == 8'h00);
            end
            if (upd.carry_en) begin
                low_next[crs_pkg::FLAG_CARRY_POS] = upd.carry_val;
            end
            // Set wins over clear so an entry is never lost
            if (upd.mask_clear) begin
                low_next[crs_pkg::FLAG_MASK_POS] = 1'b0;
            end
            if (upd.mask_set) begin
                low_next[crs_pkg::FLAG_MASK_POS] = 1'b1;
            end
        end
    end

    // Register only
    always_ff @(posedge clk) begin
        if (rst) begin
            low_reg <= crs_pkg::FLAGS_RESET[4:0];
        end else if (ce) begin
            low_reg <= low_next;
        end
    end

    assign flags = crs_pkg::FLAGS_FIXED_ONES | {3'h0, low_reg};

    chk_flags_top_ones: assert property (@(posedge clk) disable iff (rst)
        flags[7:5] == 3'h7) else $error("flags top bits not one");
    chk_flags_zero: assert property (@(posedge clk) disable iff (rst)
        ce && !load && upd.nz_en |=> flags[1] == ($past(result) == 8'h00)) else $error("zero flag wrong");
    chk_flags_neg: assert property (@(posedge clk) disable iff (rst)
        ce && !load && upd.nz_en |=> flags[2] == $past(result[7])) else $error("negative flag wrong");
    chk_flags_carry: assert property (@(posedge clk) disable iff (rst)
        ce && !load && upd.carry_en |=> flags[0] == $past(upd.carry_val)) else $error("carry flag wrong");
endmodule : crs_flags

/* rtl/crs_core_regs.sv */
// CPU core register set: accumulator, index, program counter, flags, stack
// Functional notes
// - One 8-bit accumulator for operands and results
// - Two 8-bit index registers
// - Second index never stacked on interrupts
// - 16-bit program counter from two bytes
// - Flags top three bits one, reset mask set
// - Half carry from bit 3 on add
// - Mask set on entry, cleared by software
// - Masked requests stay latched until unmasked
// - Unmask in handler takes pending at once
// - Negative flag copies result bit 7
// - Zero flag set on zero result
// - Carry set, cleared, updated by ops
// - Flags pushable, poppable and individually testable
// - Stack pointer addresses next free byte
// - Upper ten stack pointer bits fixed
// - Reset and op return pointer to top
// - Stack pointer low byte loadable, readable
// - Stack pointer wraps silently both ways
// - Program counter low byte stacked first
// - Call two bytes, interrupt five bytes
// - Entry saves counter, first index, accumulator, flags
// - Return restores context and clears mask
`timescale 1ns/10ps
module crs_core_regs (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire crs_pkg::crs_op_e op,
    input wire crs_pkg::crs_sel_e sel,
    input wire logic [7:0] wdata,
    input wire logic [15:0] pc_in,
    input wire crs_pkg::crs_flag_upd_s flag_upd,
    input wire logic [7:0] alu_result,
    input wire logic irq_req,
    input wire logic [7:0] stack_rdata,
    output crs_pkg::crs_stack_req_s stack_req,
    output logic [7:0] acc,
    output logic [7:0] idx_x,
    output logic [7:0] idx_y,
    output logic [15:0] pc,
    output logic [7:0] flags,
    output logic [15:0] sp,
    output logic irq_take,
    output logic busy
);
    // Sequencer states for multi-byte stack transfers
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ENTRY,
        ST_RETURN_RD,
        ST_RETURN_WAIT,
        ST_CALL
    } crs_state_e;

    crs_state_e state_reg; // Sequencer state
    crs_state_e state_next;
    logic [2:0] step_reg; // Byte index within a transfer
    logic [2:0] step_next;
    logic [7:0] acc_reg; // Accumulator
    logic [7:0] acc_next;
    logic [7:0] x_reg; // First index register
    logic [7:0] x_next;
    logic [7:0] y_reg; // Second index register
    logic [7:0] y_next;
    logic [15:0] pc_reg; // Program counter
    logic [15:0] pc_next;
    logic busy_reg; // Sequence running, registered for the output
    logic busy_next;
    logic [15:0] sp_cur; // Live stack pointer
    logic pending_reg; // Latched interrupt request
    logic pending_next;
    logic take_reg; // Entry accepted pulse
    logic take_next;
    crs_pkg::crs_stack_req_s req_reg; // Stack memory request
    crs_pkg::crs_stack_req_s req_next;
    logic pop_phase_reg; // Pop data arrives one cycle after the read
    logic pop_phase_next;
    crs_pkg::crs_sel_e pop_sel_reg; // Target of a plain pop
    crs_pkg::crs_sel_e pop_sel_next;
    logic sp_dec; // Stack pointer controls
    logic sp_inc;
    logic sp_load;
    logic sp_top;
    logic flags_load;
    logic [7:0] flags_load_val;
    logic [7:0] flags_cur;
    crs_pkg::crs_flag_upd_s upd_mix;

    // Stack pointer sub-block
    crs_stack_ptr #(
        .LOW_W(6)
    ) u_sp (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .dec(sp_dec),
        .inc(sp_inc),
        .load_low(sp_load),
        .reset_top(sp_top),
        .low_in(wdata),
        .sp(sp_cur)
    );

    // Flags sub-block
    crs_flags u_flags (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .upd(upd_mix),
        .result(alu_result),
        .load(flags_load),
        .load_val(flags_load_val),
        .flags(flags_cur)
    );

    // Next-state logic for the whole set
    always_comb begin
        state_next = state_reg;
        step_next = step_reg;
        acc_next = acc_reg;
        x_next = x_reg;
        y_next = y_reg;
        pc_next = pc_reg;
        take_next = 1'b0;
        req_next = '0;
        pop_phase_next = 1'b0;
        pop_sel_next = pop_sel_reg;
        sp_dec = 1'b0;
        sp_inc = 1'b0;
        sp_load = 1'b0;
        sp_top = 1'b0;
        flags_load = 1'b0;
        flags_load_val = flags_cur;
        upd_mix = '0;
        // Request latches and holds while masked; cleared only on entry
        pending_next = pending_reg | irq_req;
        // Data of a plain pop lands one cycle after the read
        if (pop_phase_reg) begin
            unique case (pop_sel_reg)
                crs_pkg::CRS_SEL_ACC: acc_next = stack_rdata;
                crs_pkg::CRS_SEL_IDX_X: x_next = stack_rdata;
                crs_pkg::CRS_SEL_IDX_Y: y_next = stack_rdata;
                crs_pkg::CRS_SEL_FLAGS: begin
                    flags_load = 1'b1;
                    flags_load_val = stack_rdata;
                end
            endcase
        end
        unique case (state_reg)
            ST_IDLE: begin
                upd_mix = flag_upd;
                // Pending taken as soon as mask reads clear, any priority
                if (pending_reg && !flags_cur[crs_pkg::FLAG_MASK_POS]) begin
                    state_next = ST_ENTRY;
                    step_next = 3'h0;
                    take_next = 1'b1;
                    pending_next = irq_req;
                    upd_mix = '0;
                end else begin
                    unique case (op)
                        crs_pkg::CRS_OP_WRITE_ACC: acc_next = wdata;
                        crs_pkg::CRS_OP_WRITE_IDX_X: x_next = wdata;
                        crs_pkg::CRS_OP_WRITE_IDX_Y: y_next = wdata;
                        crs_pkg::CRS_OP_LOAD_PC: pc_next = pc_in;
                        crs_pkg::CRS_OP_LOAD_SP_LOW: sp_load = 1'b1;
                        crs_pkg::CRS_OP_RESET_SP: sp_top = 1'b1;
                        crs_pkg::CRS_OP_PUSH: begin
                            // Write at free byte, then step down
                            req_next.wr = 1'b1;
                            req_next.addr = sp_cur;
                            unique case (sel)
                                crs_pkg::CRS_SEL_ACC: req_next.data = acc_reg;
                                crs_pkg::CRS_SEL_IDX_X: req_next.data = x_reg;
                                crs_pkg::CRS_SEL_IDX_Y: req_next.data = y_reg;
                                crs_pkg::CRS_SEL_FLAGS: req_next.data = flags_cur;
                            endcase
                            sp_dec = 1'b1;
                        end
                        crs_pkg::CRS_OP_POP: begin
                            // Step up before reading
                            sp_inc = 1'b1;
                            req_next.rd = 1'b1;
                            req_next.addr = {sp_cur[15:6], sp_cur[5:0] + 6'h01};
                            pop_phase_next = 1'b1;
                            pop_sel_next = sel;
                        end
                        crs_pkg::CRS_OP_CALL: begin
                            state_next = ST_CALL;
                            step_next = 3'h0;
                        end
                        crs_pkg::CRS_OP_IRQ_ENTRY: begin
                            // Software trap ignores the mask
                            state_next = ST_ENTRY;
                            step_next = 3'h0;
                        end
                        crs_pkg::CRS_OP_IRQ_RETURN: begin
                            state_next = ST_RETURN_RD;
                            step_next = 3'h0;
                        end
                        default: begin
                        end
                    endcase
                end
            end
            ST_CALL: begin
                // Return address takes two bytes, low byte first
                req_next.wr = 1'b1;
                req_next.addr = sp_cur;
                req_next.data = (step_reg == 3'h0) ? pc_reg[7:0] : pc_reg[15:8];
                sp_dec = 1'b1;
                step_next = step_reg + 3'h1;
                if (step_reg == 3'(crs_pkg::CALL_STACK_BYTES - 1)) begin
                    state_next = ST_IDLE;
                    pc_next = pc_in;
                end
            end
            ST_ENTRY: begin
                // Five bytes at falling addresses; second index left alone
                req_next.wr = 1'b1;
                req_next.addr = sp_cur;
                sp_dec = 1'b1;
                unique case (step_reg)
                    3'h0: req_next.data = pc_reg[7:0];
                    3'h1: req_next.data = pc_reg[15:8];
                    3'h2: req_next.data = x_reg;
                    3'h3: req_next.data = acc_reg;
                    default: req_next.data = flags_cur;
                endcase
                step_next = step_reg + 3'h1;
                if (step_reg == 3'(crs_pkg::IRQ_STACK_BYTES - 1)) begin
                    state_next = ST_IDLE;
                    pc_next = pc_in; // Vector from the caller
                    upd_mix.mask_set = 1'b1;
                end
            end
            ST_RETURN_RD: begin
                // Pop in reverse order: flags, acc, x, pc high, pc low
                sp_inc = 1'b1;
                req_next.rd = 1'b1;
                req_next.addr = {sp_cur[15:6], sp_cur[5:0] + 6'h01};
                state_next = ST_RETURN_WAIT;
            end
            ST_RETURN_WAIT: begin
                unique case (step_reg)
                    3'h0: begin
                        flags_load = 1'b1;
                        flags_load_val = stack_rdata & ~(8'h01 << crs_pkg::FLAG_MASK_POS);
                    end
                    3'h1: acc_next = stack_rdata;
                    3'h2: x_next = stack_rdata;
                    3'h3: pc_next = {stack_rdata, pc_reg[7:0]};
                    default: pc_next = {pc_reg[15:8], stack_rdata};
                endcase
                step_next = step_reg + 3'h1;
                state_next = (step_reg == 3'(crs_pkg::IRQ_STACK_BYTES - 1)) ? ST_IDLE : ST_RETURN_RD;
            end
        endcase
        // Busy follows the state that the sequencer is about to enter
        busy_next = (state_next != ST_IDLE);
    end

    // Register stage
    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= ST_IDLE;
            step_reg <= 3'h0;
            acc_reg <= crs_pkg::DATA_RESET;
            x_reg <= crs_pkg::DATA_RESET;
            y_reg <= crs_pkg::DATA_RESET;
            pc_reg <= crs_pkg::PC_RESET;
            pending_reg <= 1'b0;
            take_reg <= 1'b0;
            req_reg <= '0;
            pop_phase_reg <= 1'b0;
            pop_sel_reg <= crs_pkg::CRS_SEL_ACC;
            busy_reg <= 1'b0;
        end else if (ce) begin
            state_reg <= state_next;
            step_reg <= step_next;
            acc_reg <= acc_next;
            x_reg <= x_next;
            y_reg <= y_next;
            pc_reg <= pc_next;
            pending_reg <= pending_next;
            take_reg <= take_next;
            req_reg <= req_next;
            pop_phase_reg <= pop_phase_next;
            pop_sel_reg <= pop_sel_next;
            busy_reg <= busy_next;
        end
    end

    // Outputs straight from flip-flops (sub-block registers included)
    assign acc = acc_reg;
    assign idx_x = x_reg;
    assign idx_y = y_reg;
    assign pc = pc_reg;
    assign flags = flags_cur;
    assign sp = sp_cur;
    assign irq_take = take_reg;
    assign stack_req = req_reg;
    assign busy = busy_reg;

    chk_entry_mask_set: assert property (@(posedge clk) disable iff (rst)
        ce && state_reg == ST_ENTRY && step_reg == 3'h4 |=> flags_cur[3]) else $error("mask not set on entry");
    chk_entry_pcl_first: assert property (@(posedge clk) disable iff (rst)
        ce && state_reg == ST_ENTRY && step_reg == 3'h0 |=> req_reg.wr && req_reg.data == $past(pc_reg[7:0]))
        else $error("entry did not stack low pc first");
    chk_entry_no_y: assert property (@(posedge clk) disable iff (rst)
        ce && state_reg == ST_ENTRY |=> y_reg == $past(y_reg)) else $error("second index touched on entry");
    chk_pending_held: assert property (@(posedge clk) disable iff (rst)
        ce && pending_reg && flags_cur[3] && state_reg == ST_IDLE |=> pending_reg)
        else $error("masked request lost");
    chk_unmask_take: assert property (@(posedge clk) disable iff (rst)
        ce && pending_reg && !flags_cur[3] && state_reg == ST_IDLE |=> take_reg)
        else $error("pending not taken when unmasked");
    chk_return_mask: assert property (@(posedge clk) disable iff (rst)
        ce && state_reg == ST_RETURN_WAIT && step_reg == 3'h0 |=> !flags_cur[3]) else $error("return kept mask");
    // Stack traffic follows the pointer and the fixed byte order
    chk_push_addr: assert property (@(posedge clk) disable iff (rst)
        ce && state_reg == ST_IDLE && op == crs_pkg::CRS_OP_PUSH && !take_next
        |=> req_reg.wr && req_reg.addr == $past(sp_cur) && sp_cur[5:0] == $past(sp_cur[5:0]) - 6'h01)
        else $error("push address wrong");
    chk_pop_addr: assert property (@(posedge clk) disable iff (rst)
        ce && state_reg == ST_IDLE && op == crs_pkg::CRS_OP_POP && !take_next
        |=> req_reg.rd && req_reg.addr == sp_cur)
        else $error("pop address wrong");
    chk_call_two_bytes: assert property (@(posedge clk) disable iff (rst)
        ce && state_reg == ST_CALL && step_reg == 3'h1
        |=> !busy_reg && req_reg.wr && req_reg.data == $past(pc_reg[15:8]))
        else $error("call not two bytes");
    chk_return_pcl_last: assert property (@(posedge clk) disable iff (rst)
        ce && state_reg == ST_RETURN_WAIT && step_reg == 3'h4
        |=> !busy_reg && pc_reg[7:0] == $past(stack_rdata))
        else $error("return not ended on low pc");
    // Main scenarios reached
    cov_entry: cover property (@(posedge clk) take_reg);
    cov_return: cover property (@(posedge clk) state_reg == ST_RETURN_WAIT && step_reg == 3'h4);
    cov_call: cover property (@(posedge clk) state_reg == ST_CALL);
    cov_masked_wait: cover property (@(posedge clk) pending_reg && flags_cur[3] && state_reg == ST_IDLE);
    cov_pop_flags: cover property (@(posedge clk) pop_phase_reg && pop_sel_reg == crs_pkg::CRS_SEL_FLAGS);
endmodule : crs_core_regs

/* verif/tb_crs_core_regs.sv */
// Self-checking bench for the CPU core register set
`timescale 1ns/10ps
module tb_crs_core_regs;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    crs_pkg::crs_op_e op = crs_pkg::CRS_OP_NONE;
    crs_pkg::crs_sel_e sel = crs_pkg::CRS_SEL_ACC;
    logic [7:0] wdata = 8'h00;
    logic [15:0] pc_in = 16'h0000;
    crs_pkg::crs_flag_upd_s flag_upd = '0;
    logic [7:0] alu_result = 8'h00;
    logic irq_req = 1'b0;
    logic [7:0] stack_rdata = 8'h00;
    crs_pkg::crs_stack_req_s stack_req;
    logic [7:0] acc, idx_x, idx_y, flags;
    logic [15:0] pc, sp;
    logic irq_take, busy;
    int failures = 0;
    int n_compared = 0;
    int cycles = 0;
    int takes = 0;
    logic [31:0] seed = 32'haa556f44;
    // Bytes the design wrote, and bytes the model expects
    logic [7:0] mem [int];
    logic [7:0] m_mem [int];
    int m_acc, m_x, m_y, m_pc, m_fl, m_sp, v;

    crs_core_regs u_crs_core_regs (.clk(clk), .rst(rst), .ce(ce), .op(op), .sel(sel), .wdata(wdata),
        .pc_in(pc_in), .flag_upd(flag_upd), .alu_result(alu_result), .irq_req(irq_req),
        .stack_rdata(stack_rdata), .stack_req(stack_req), .acc(acc), .idx_x(idx_x), .idx_y(idx_y),
        .pc(pc), .flags(flags), .sp(sp), .irq_take(irq_take), .busy(busy));

    // Clock at 125 MHz
    always #4 clk = ~clk;

    // Stack memory; a released read bus shows a changing pattern, not stale data
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (stack_req.wr === 1'b1) mem[stack_req.addr] = stack_req.data;
        if (irq_take === 1'b1) takes <= takes + 1;
        if (cycles > 20000) begin
            failures = failures + 1;
            end_of_test();
        end
    end
    always @(negedge clk) begin
        stack_rdata <= (stack_req.rd === 1'b1) ? mem[stack_req.addr] : ~stack_rdata;
    end

    // Xorshift source with a fixed seed
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    // Pointer step inside the 64-byte window, upper ten bits held
    function automatic int spm(input int s, input int d);
        return (s & 'hffc0) | ((s + d) & 'h3f);
    endfunction : spm

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic end_of_test();
        if (failures == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : end_of_test

    task automatic check_all();
        chk(acc, m_acc);
        chk(idx_x, m_x);
        chk(idx_y, m_y);
        chk(pc, m_pc);
        chk(flags, m_fl);
        chk(sp, m_sp);
    endtask : check_all

    // Model push: the design's byte must sit where the pointer was
    task automatic mpush(input int d);
        m_mem[m_sp] = d[7:0];
        chk(mem[m_sp], d[7:0]);
        m_sp = spm(m_sp, -1);
    endtask : mpush

    function automatic int mpop();
        m_sp = spm(m_sp, 1);
        return m_mem[m_sp];
    endfunction : mpop

    // One operation, then wait until the sequence has finished
    task automatic run(input crs_pkg::crs_op_e o, input crs_pkg::crs_sel_e s, input logic [7:0] w);
        op = o;
        sel = s;
        wdata = w;
        @(negedge clk);
        op = crs_pkg::CRS_OP_NONE;
        repeat (2) @(negedge clk);
        for (int i = 0; i < 40 && busy !== 1'b0; i++) @(negedge clk);
        // Last stack write is registered and lands one edge later
        @(negedge clk);
    endtask : run

    task automatic fl(input crs_pkg::crs_flag_upd_s u, input logic [7:0] r);
        flag_upd = u;
        alu_result = r;
        @(negedge clk);
        flag_upd = '0;
        repeat (2) @(negedge clk);
        if (u.half_en) m_fl = u.half_val ? m_fl | 16 : m_fl & ~16;
        if (u.nz_en) m_fl = (m_fl & ~6) | (r[7] ? 4 : 0) | (r == 8'h00 ? 2 : 0);
        if (u.carry_en) m_fl = (m_fl & ~1) | u.carry_val;
        if (u.mask_clear) m_fl = m_fl & ~8;
        if (u.mask_set) m_fl = m_fl | 8;
    endtask : fl

    // Main sequence
    initial begin
        crs_pkg::crs_flag_upd_s u;
        crs_pkg::crs_sel_e s;
        s = crs_pkg::CRS_SEL_ACC;
        repeat (5) @(negedge clk);
        rst = 1'b0;
        m_acc = 0;
        m_x = 0;
        m_y = 0;
        m_pc = 0;
        m_fl = 'he8;
        m_sp = 'h017f;
        @(negedge clk);
        check_all();
        // Random data writes and flag updates, mask left set
        for (int i = 0; i < 12; i++) begin
            v = rnd();
            run(crs_pkg::CRS_OP_WRITE_ACC, s, v[7:0]);
            m_acc = v[7:0];
            run(crs_pkg::CRS_OP_WRITE_IDX_X, s, v[15:8]);
            m_x = v[15:8];
            run(crs_pkg::CRS_OP_WRITE_IDX_Y, s, v[23:16]);
            m_y = v[23:16];
            pc_in = rnd();
            run(crs_pkg::CRS_OP_LOAD_PC, s, 8'h00);
            m_pc = pc_in;
            u = rnd();
            u.mask_clear = 1'b0;
            fl(u, (i == 3) ? 8'h00 : v[31:24]);
            check_all();
        end
        // A stopped clock enable freezes everything
        ce = 1'b0;
        run(crs_pkg::CRS_OP_WRITE_ACC, s, 8'h5a);
        ce = 1'b1;
        check_all();
        // Pushes beyond 64 bytes wrap silently, then pops come back
        for (int i = 0; i < 66; i++) begin
            s = crs_pkg::crs_sel_e'(rnd() & 3);
            run(crs_pkg::CRS_OP_PUSH, s, 8'h00);
            mpush(s == crs_pkg::CRS_SEL_ACC ? m_acc : s == crs_pkg::CRS_SEL_IDX_X ? m_x :
                s == crs_pkg::CRS_SEL_IDX_Y ? m_y : m_fl);
        end
        for (int i = 0; i < 4; i++) begin
            s = crs_pkg::crs_sel_e'(i);
            run(crs_pkg::CRS_OP_POP, s, 8'h00);
            v = mpop();
            if (i == 0) m_acc = v;
            if (i == 1) m_x = v;
            if (i == 2) m_y = v;
            if (i == 3) m_fl = v | 'he0;
            check_all();
        end
        // Pointer low byte load and reset to the top
        run(crs_pkg::CRS_OP_LOAD_SP_LOW, s, 8'hc5);
        m_sp = 'h0145;
        check_all();
        run(crs_pkg::CRS_OP_RESET_SP, s, 8'h00);
        m_sp = 'h017f;
        check_all();
        // Call uses two bytes, low byte first
        pc_in = rnd();
        run(crs_pkg::CRS_OP_CALL, s, 8'h00);
        mpush(m_pc);
        mpush(m_pc >> 8);
        m_pc = pc_in;
        check_all();
        // Request while masked stays latched, no entry
        u = '0;
        u.mask_set = 1'b1;
        fl(u, 8'h00);
        irq_req = 1'b1;
        @(negedge clk);
        irq_req = 1'b0;
        repeat (6) @(negedge clk);
        chk(takes, 0);
        check_all();
        // Unmasking takes it at once: five bytes, pointer copy order
        pc_in = rnd();
        u = '0;
        u.mask_clear = 1'b1;
        fl(u, 8'h00);
        chk(busy, 1'b1);
        for (int i = 0; i < 40 && busy !== 1'b0; i++) @(negedge clk);
        @(negedge clk);
        chk(takes, 1);
        mpush(m_pc);
        mpush(m_pc >> 8);
        mpush(m_x);
        mpush(m_acc);
        mpush(m_fl);
        m_pc = pc_in;
        m_fl = m_fl | 8;
        check_all();
        // Return restores context with the mask cleared; then a trap and return
        for (int k = 0; k < 2; k++) begin
            if (k == 1) begin
                pc_in = rnd();
                run(crs_pkg::CRS_OP_IRQ_ENTRY, s, 8'h00);
                mpush(m_pc);
                mpush(m_pc >> 8);
                mpush(m_x);
                mpush(m_acc);
                mpush(m_fl);
                m_pc = pc_in;
                m_fl = m_fl | 8;
                check_all();
            end
            run(crs_pkg::CRS_OP_IRQ_RETURN, s, 8'h00);
            m_fl = (mpop() | 'he0) & ~8;
            m_acc = mpop();
            m_x = mpop();
            m_pc = mpop() << 8;
            m_pc = m_pc | mpop();
            check_all();
        end
        chk(takes, 1);
        end_of_test();
    end
endmodule : tb_crs_core_regs
